// file: verilog/owd_pkg.sv
// Constants, types and helpers for the option word decoder
//
// Notes on behaviour
// - Bit 7 of the option word is unimplemented and always reads back as one.
// - Bit 6 set enables brown-out detection and bit 6 clear disables it.
// - Bit 3 is active low: zero enables the power-up delay timer and one disables it.
// - Bit 2 set runs the watchdog timer and bit 2 clear keeps it off.
// - Bits 1 to 0 select the oscillator: 11 R-C, 10 high-speed, 01 standard, 00 low-power.
// - While brown-out reset is enabled the power-up delay timer is forced on.
// - Protection code 00 blocks readout of the whole range 0000h to 03FFh.
// - Protection code 11 leaves memory open and code 01 blocks only 0200h to 03FFh.
// - The two-bit protection code is copied at bits 13-12, 11-10, 9-8 and 5-4.
package owd_pkg;
    localparam int WORD_W = 14;
    localparam logic [13:0] WORD_RESET = 14'h3FFF;
    localparam int BIT_UNIMP = 7;
    localparam int BIT_BROWNOUT = 6;
    localparam int BIT_PWRDLY_N = 3;
    localparam int BIT_WDOG = 2;
    localparam int OSC_LSB = 0;
    localparam int CP_LSB_A = 12;
    localparam int CP_LSB_B = 10;
    localparam int CP_LSB_C = 8;
    localparam int CP_LSB_D = 4;
    localparam logic [1:0] OSC_RES_CAP = 2'h3;
    localparam logic [1:0] OSC_FAST_XTAL = 2'h2;
    localparam logic [1:0] OSC_STD_XTAL = 2'h1;
    localparam logic [1:0] OSC_SLOW_XTAL = 2'h0;
    localparam logic [1:0] CP_ALL = 2'h0;
    localparam logic [1:0] CP_UPPER = 2'h1;
    localparam logic [9:0] PROT_UPPER_LO = 10'h200;
    localparam logic [7:0] OFS_WORD = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam int ST_BROWNOUT = 0;
    localparam int ST_PWRDLY = 1;
    localparam int ST_WDOG = 2;
    localparam int ST_OSC_LSB = 3;
    localparam int ST_PROT_LSB = 5;
    localparam int ST_MISMATCH = 7;
    localparam int CTRL_HOLD = 0;
    localparam logic CTRL_RESET = 1'b0;

    typedef enum logic [1:0] {PROT_NONE, PROT_UPPER, PROT_ALL} owd_prot_e;

    function automatic logic prot_covers(owd_prot_e range, logic [9:0] addr);
        prot_covers = (range == PROT_ALL) || ((range == PROT_UPPER) && (addr >= PROT_UPPER_LO));
    endfunction
endpackage

// file: verilog/owd_dec_if.sv
// Bundle between the option word holder and its decoder
`timescale 1ns/1ps
`default_nettype none
interface owd_dec_if;
    logic [13:0] word;
    logic brownout_en;
    logic powerup_en;
    logic watchdog_en;
    logic [1:0] osc_mode;
    owd_pkg::owd_prot_e prot;
    logic prot_mismatch;
    modport decoder(input word, output brownout_en, powerup_en, watchdog_en, osc_mode, prot,
                    prot_mismatch);
    modport owner(output word, input brownout_en, powerup_en, watchdog_en, osc_mode, prot,
                  prot_mismatch);
endinterface
`default_nettype wire

// file: verilog/owd_decode.sv
// Combinational field decoder for the option word
`timescale 1ns/1ps
`default_nettype none
module owd_decode (
    owd_dec_if.decoder dec
);
    wire [1:0] cp_a = dec.word[owd_pkg::CP_LSB_A +: 2];
    wire [1:0] cp_b = dec.word[owd_pkg::CP_LSB_B +: 2];
    wire [1:0] cp_c = dec.word[owd_pkg::CP_LSB_C +: 2];
    wire [1:0] cp_d = dec.word[owd_pkg::CP_LSB_D +: 2];
    wire cp_agree = (cp_a == cp_d) && (cp_b == cp_d) && (cp_c == cp_d);

    assign dec.brownout_en = dec.word[owd_pkg::BIT_BROWNOUT];
    // Brown-out forces the delay on, so a bad fuse pair cannot skip it
    assign dec.powerup_en = !dec.word[owd_pkg::BIT_PWRDLY_N] || dec.brownout_en;
    assign dec.watchdog_en = dec.word[owd_pkg::BIT_WDOG];
    assign dec.osc_mode = dec.word[owd_pkg::OSC_LSB +: 2];
    assign dec.prot_mismatch = !cp_agree;
    assign dec.prot = !cp_agree ? owd_pkg::PROT_NONE :
                      (cp_d == owd_pkg::CP_ALL) ? owd_pkg::PROT_ALL :
                      (cp_d == owd_pkg::CP_UPPER) ? owd_pkg::PROT_UPPER :
                      owd_pkg::PROT_NONE;
endmodule
`default_nettype wire

// file: verilog/owd_top.sv
// Option word capture, decoded control outputs and AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module owd_top (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [13:0] option_word_pins,
    input wire logic [9:0] verify_addr,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic brownout_detect_enable,
    output logic powerup_delay_enable,
    output logic watchdog_timer_enable,
    output logic [1:0] osc_mode_select,
    output logic readout_blocked,
    output logic protect_mismatch
);
    localparam logic [13:0] WR = owd_pkg::WORD_RESET;
    localparam logic BROWNOUT_RST = WR[owd_pkg::BIT_BROWNOUT];
    localparam logic PWR_RST = !WR[owd_pkg::BIT_PWRDLY_N] || BROWNOUT_RST;

    owd_dec_if dec_bus();

    owd_decode u_decode (
        .dec(dec_bus)
    );

    // Fuse levels come from outside the clock domain
    logic [13:0] pin_meta_r;
    logic [13:0] pin_sync_r;
    logic [13:0] word_r;
    logic ctrl_hold_r;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pin_meta_r <= WR;
            pin_sync_r <= WR;
        end else begin
            pin_meta_r <= option_word_pins;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Hold lets software freeze the decode while the fuse array is being reprogrammed
    wire [13:0] word_nxt = ctrl_hold_r ? word_r : pin_sync_r;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            word_r <= WR;
        end else begin
            word_r <= word_nxt;
        end
    end

    assign dec_bus.word = word_r;

    wire blocked_nxt = owd_pkg::prot_covers(dec_bus.prot, verify_addr);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            brownout_detect_enable <= BROWNOUT_RST;
            powerup_delay_enable <= PWR_RST;
            watchdog_timer_enable <= WR[owd_pkg::BIT_WDOG];
            osc_mode_select <= WR[owd_pkg::OSC_LSB +: 2];
            readout_blocked <= 1'b0;
            protect_mismatch <= 1'b0;
        end else begin
            brownout_detect_enable <= dec_bus.brownout_en;
            powerup_delay_enable <= dec_bus.powerup_en;
            watchdog_timer_enable <= dec_bus.watchdog_en;
            osc_mode_select <= dec_bus.osc_mode;
            readout_blocked <= blocked_nxt;
            protect_mismatch <= dec_bus.prot_mismatch;
        end
    end

    // Zero wait state slave: every access completes in one data phase
    logic wr_pend_r;
    logic [7:0] wr_ofs_r;
    wire addr_ok = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
    wire take = hsel && hready && htrans[1];
    wire [7:0] ofs = haddr[7:0];
    wire ctrl_wr = wr_pend_r && (wr_ofs_r == owd_pkg::OFS_CTRL);
    // Bypass so a read right behind a control write sees the new value
    wire ctrl_view = ctrl_wr ? hwdata[owd_pkg::CTRL_HOLD] : ctrl_hold_r;
    wire [13:0] unimp_mask = 14'h0001 << owd_pkg::BIT_UNIMP;
    wire [13:0] word_rd = word_r | unimp_mask;
    wire [7:0] status_rd = {protect_mismatch, dec_bus.prot, osc_mode_select,
                            watchdog_timer_enable, powerup_delay_enable,
                            brownout_detect_enable};
    wire [31:0] rd_nxt = !addr_ok ? 32'h0000_0000 :
                         (ofs == owd_pkg::OFS_WORD) ? {18'h0_0000, word_rd} :
                         (ofs == owd_pkg::OFS_STATUS) ? {24'h00_0000, status_rd} :
                         (ofs == owd_pkg::OFS_CTRL) ? {31'h0000_0000, ctrl_view} :
                         32'h0000_0000;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_pend_r <= 1'b0;
            wr_ofs_r <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend_r <= take && hwrite && addr_ok;
            wr_ofs_r <= ofs;
            if (take && !hwrite) begin
                hrdata <= rd_nxt;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl_hold_r <= owd_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_hold_r <= hwdata[owd_pkg::CTRL_HOLD];
        end
    end

    default clocking dflt_cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    logic past_valid_r;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            past_valid_r <= 1'b0;
        end else begin
            past_valid_r <= 1'b1;
        end
    end

    sequence s_read_word;
        take && !hwrite && addr_ok && (ofs == owd_pkg::OFS_WORD);
    endsequence

    sequence s_write_hold;
        take && hwrite && addr_ok && (ofs == owd_pkg::OFS_CTRL) ##1 hwdata[0];
    endsequence

    // Bus side: address phases as the slave takes them
    sequence s_ctrl_write;
        take && hwrite && addr_ok && (ofs == owd_pkg::OFS_CTRL);
    endsequence

    sequence s_other_write;
        take && hwrite && !(addr_ok && (ofs == owd_pkg::OFS_CTRL));
    endsequence

    sequence s_read_ctrl;
        take && !hwrite && addr_ok && (ofs == owd_pkg::OFS_CTRL) && !ctrl_wr;
    endsequence

    sequence s_read_status;
        take && !hwrite && addr_ok && (ofs == owd_pkg::OFS_STATUS);
    endsequence

    wire [1:0] cp_d = word_r[owd_pkg::CP_LSB_D +: 2];
    wire cp_same = (word_r[13:12] == cp_d) && (word_r[11:10] == cp_d) && (word_r[9:8] == cp_d);

    a_unimp_reads_one: assert property (s_read_word |=> hrdata[7] == 1'b1)
        else $error("unimplemented bit read back as zero");
    a_brownout_follows_fuse: assert property (past_valid_r |->
        brownout_detect_enable == $past(word_r[6]))
        else $error("brown-out enable does not follow its fuse");
    a_pwrdly_active_low: assert property (past_valid_r && !$past(word_r[6]) |->
        powerup_delay_enable == !$past(word_r[3]))
        else $error("power-up delay enable has wrong polarity");
    a_watchdog_follows: assert property (past_valid_r |->
        watchdog_timer_enable == $past(word_r[2]))
        else $error("watchdog enable does not follow its fuse");
    a_osc_mode_decode: assert property (past_valid_r |->
        osc_mode_select == $past(word_r[1:0]))
        else $error("oscillator mode does not follow its field");
    a_brownout_forces_delay: assert property (brownout_detect_enable |->
        powerup_delay_enable)
        else $error("brown-out enabled without power-up delay");
    a_protect_all_range: assert property (cp_same && cp_d == 2'h0 |=>
        readout_blocked)
        else $error("code 00 left an address readable");
    a_protect_upper_range: assert property (cp_same && cp_d == 2'h1 |=>
        readout_blocked == ($past(verify_addr) >= 10'h200))
        else $error("code 01 protected the wrong range");
    a_protect_off_codes: assert property (cp_same && cp_d[1] |=> !readout_blocked)
        else $error("open code still blocked readout");
    a_pair_mismatch_open: assert property (!cp_same |=>
        protect_mismatch && !readout_blocked)
        else $error("disagreeing copies applied protection");
    a_capture_latency: assert property (past_valid_r && $past(!ctrl_hold_r) &&
        $past(past_valid_r, 3) |-> word_r == $past(option_word_pins, 3))
        else $error("fuse pins not captured three cycles later");
    a_hold_freezes_word: assert property (s_write_hold |=> ctrl_hold_r ##1 $stable(word_r))
        else $error("hold did not freeze the option word");
    // A write lands at the end of its data phase, one edge after its address
    a_ctrl_write_lands: assert property (s_ctrl_write ##1 1'b1 |=>
        ctrl_hold_r == $past(hwdata[owd_pkg::CTRL_HOLD]))
        else $error("control write did not land");
    a_other_write_ignored: assert property (s_other_write |-> ##2 $stable(ctrl_hold_r))
        else $error("write elsewhere changed the hold bit");
    a_ctrl_read_back: assert property (s_read_ctrl |=>
        hrdata == {31'h0000_0000, $past(ctrl_hold_r)})
        else $error("control read returned a stale value");
    a_unmapped_reads_zero: assert property (take && !hwrite && !addr_ok |=>
        hrdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_read_data_stands: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_word_read_value: assert property (s_read_word |=>
        hrdata == {18'h0_0000, $past(word_r) | unimp_mask})
        else $error("option word read back wrongly");
    a_status_mismatch_bit: assert property (s_read_status |=>
        hrdata[owd_pkg::ST_MISMATCH] == $past(protect_mismatch))
        else $error("status mismatch bit disagrees with output");
endmodule
`default_nettype wire

// file: test/owd_top_tb.sv
// Self-checking bench for the option word decoder and its register slave
`timescale 1ns/1ps
`default_nettype none
module owd_top_tb;
    logic ref_clk, reset, hsel, hwrite, hready, hresp, bo, pwr, wd, blk, mis;
    logic [13:0] pins, w0;
    logic [9:0] vaddr;
    logic [31:0] haddr, hwdata, hrdata, rd, r;
    logic [1:0] htrans, osc;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] xs_state = 32'h0000_0020;
    logic [13:0] corner [6] = '{14'h0000, 14'h1558, 14'h3FBF, 14'h3FCF, 14'h2A26, 14'h1511};

    owd_top owd_top_i (.ref_clk(ref_clk), .reset(reset), .option_word_pins(pins),
        .verify_addr(vaddr), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .brownout_detect_enable(bo), .powerup_delay_enable(pwr),
        .watchdog_timer_enable(wd), .osc_mode_select(osc), .readout_blocked(blk),
        .protect_mismatch(mis));

    function automatic logic [31:0] xs();
        logic [31:0] x;
        x = xs_state;
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        xs_state = x;
        return x;
    endfunction

    // Status layout: mismatch, range(2), osc(2), watchdog, power-up delay, brown-out
    function automatic logic [7:0] exp_status(input logic [13:0] w);
        logic agree;
        logic [1:0] p;
        agree = (w[11:10] == w[13:12]) && (w[9:8] == w[13:12]) && (w[5:4] == w[13:12]);
        p = !agree ? 2'h0 : (w[13:12] == 2'h0) ? 2'h2 : (w[13:12] == 2'h1) ? 2'h1 : 2'h0;
        return {~agree, p, w[1:0], w[2], w[6] | ~w[3], w[6]};
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
    endtask

    task automatic chk_out(input logic [13:0] w);
        logic [7:0] s;
        s = exp_status(w);
        chk("outputs", {26'h0, s[7], s[4:0]}, {26'h0, mis, osc, wd, pwr, bo});
    endtask

    task automatic check_word(input logic [13:0] w);
        logic [7:0] s;
        logic [9:0] a;
        s = exp_status(w);
        @(posedge ref_clk);
        pins <= w;
        repeat (6) @(posedge ref_clk);
        chk_out(w);
        for (int i = 0; i < 3; i++) begin
            r = xs();
            a = (i == 0) ? 10'h1FF : (i == 1) ? 10'h200 : r[9:0];
            vaddr <= a;
            repeat (2) @(posedge ref_clk);
            chk("blocked", {31'h0, s[6:5] == 2'h2 || (s[6:5] == 2'h1 && a >= 10'h200)},
                {31'h0, blk});
        end
        bus(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk("word", {18'h0, w | 14'h0080}, rd);
        bus(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk("status", {24'h0, s}, rd);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Generous ceiling: the whole run needs well under two thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        pins = 14'h0000;
        vaddr = 10'h000;
        repeat (4) @(posedge ref_clk);
        chk_out(14'h3FFF);
        reset <= 1'b0;
        bus(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk("reset word", 32'h0000_3FFF, rd);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            check_word(corner[i]);
        end
        check_word(14'h3FF7);
        $display("test corners done");
        for (int i = 0; i < 12; i++) begin
            r = xs();
            check_word(r[13:0]);
        end
        $display("test random done");
        w0 = pins;
        bus(1'b1, 32'h0000_0008, 32'h0000_0001);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000);
        chk("ctrl", 32'h0000_0001, rd);
        pins <= ~w0;
        repeat (6) @(posedge ref_clk);
        chk_out(w0);
        bus(1'b1, 32'h0000_0008, 32'h0000_0000);
        bus(1'b1, 32'h0000_0000, 32'hFFFF_FFFF);
        repeat (6) @(posedge ref_clk);
        chk_out(~w0);
        bus(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk("ro word", {18'h0, ~w0 | 14'h0080}, rd);
        bus(1'b0, 32'h0000_000C, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        bus(1'b0, 32'h0000_0100, 32'h0000_0000);
        chk("upper address", 32'h0000_0000, rd);
        bus(1'b0, 32'h0000_0002, 32'h0000_0000);
        chk("unaligned", 32'h0000_0000, rd);
        $display("test hold done");
        end_sim();
    end
endmodule
`default_nettype wire
